// ---- hdl/ipt_defines.svh ----
/*
  Register offsets, field positions, reset values and fixed codes of the
  interrupt, event transfer and trap unit.
  Assumes a 12-bit APB byte address; every register is one aligned word.
*/
`ifndef IPT_DEFINES_SVH
`define IPT_DEFINES_SVH
`define IPT_NSRC 20
`define IPT_NCH 8
`define IPT_NEXT 7
`define IPT_A_TFR 12'h080
`define IPT_A_TMSK 12'h084
`define IPT_A_SOVL 12'h088
`define IPT_A_SUNL 12'h08c
`define IPT_A_EDGE 12'h090
`define IPT_A_CHB 4'h1
`define IPT_S_LVL 3:0
`define IPT_S_ROUTE 4
`define IPT_S_CH 7:5
`define IPT_S_EN 8
`define IPT_S_REQ 9
`define IPT_C_CNT 7:0
`define IPT_C_WORD 8
`define IPT_C_INCD 9
`define IPT_C_CONT 10
`define IPT_T_NMI 0
`define IPT_T_STACK_OVER_FLAG 1
`define IPT_T_STACK_UNDER_FLAG 2
`define IPT_T_BOP 3
`define IPT_T_PRT 4
`define IPT_T_BWO 5
`define IPT_T_BIA 6
`define IPT_T_BEB 7
`define IPT_T_BMASK 8'hf8
`define IPT_RST_SOVL 16'h0000
`define IPT_RST_SUNL 16'hffff
`define IPT_TN_RST 7'h00
`define IPT_TN_NMI 7'h02
`define IPT_TN_STACK_OVER_FLAG 7'h04
`define IPT_TN_STACK_UNDER_FLAG 7'h06
`define IPT_TN_B 7'h0a
`define IPT_LVL_TRAP 4'hf
`define IPT_CLS_NONE 2'h0
`define IPT_CLS_B 2'h1
`define IPT_CLS_A 2'h2
`define IPT_SRC_TN {7'h2f, 7'h2e, 7'h2d, 7'h2c, 7'h2b, 7'h47, 7'h2a, \
  7'h27, 7'h26, 7'h25, 7'h24, 7'h23, 7'h22, 7'h1f, 7'h1e, 7'h1d, \
  7'h1c, 7'h1b, 7'h1a, 7'h19}
`define IPT_LAT_MAX 12
`endif

// ---- hdl/ipt_pkg.sv ----
/*
  Types of the interrupt, event transfer and trap unit.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ipt_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_VEC = 3'b010,
    ST_XFER = 3'b100
  } ipt_state_e;
  typedef enum logic [2:0] {
    K_RST = 3'h0,
    K_A = 3'h1,
    K_B = 3'h2,
    K_SWT = 3'h3,
    K_INT = 3'h4
  } ipt_kind_e;
  typedef struct packed {
    logic [6:0] num;
    logic [8:0] addr;
    logic [3:0] lvl;
  } ipt_vec_s;
  typedef struct packed {
    logic [15:0] src;
    logic [15:0] dst;
    logic word;
  } ipt_xfer_s;
  typedef struct packed {
    logic nmi;
    logic bad_opcode;
    logic prot_fault;
    logic bad_word_op;
    logic bad_instr;
    logic bad_bus;
    logic soft_rst;
    logic wdt_ovf;
  } ipt_trap_s;
endpackage : ipt_pkg

// ---- hdl/ipt_top.sv ----
/*
  Interrupt controller with event transfer channels and trap handling.
  Assumes an APB master, a core that acknowledges each vector or transfer
  with a one-cycle pulse, EXT_IN as async pins and all else on CLOCK.
*/
`timescale 1ns/1ps
`include "ipt_defines.svh"
module ipt_top (
  input wire logic CLOCK, // 200 MHz
  input wire logic RESETN, // async, active low
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb access phase
  input wire logic PWRITE, // apb direction
  input wire logic [11:0] PADDR, // apb byte address
  input wire logic [31:0] PWDATA, // apb write data
  output logic [31:0] PRDATA, // apb read data
  output logic PREADY, // apb ready
  output logic PSLVERR, // unmapped address
  input wire logic [19:0] SRC_REQ, // peripheral request pulses
  input wire logic [6:0] EXT_IN, // fast external interrupt pins
  input wire ipt_pkg::ipt_trap_s TRAP_IN, // trap condition pulses
  input wire logic STK_ACC, // stack access strobe
  input wire logic [15:0] STK_PTR, // stack_top_pointer value
  input wire logic [3:0] CPU_PRIO, // current core level
  input wire logic SWT_REQ, // software trap strobe
  input wire logic [6:0] SWT_NUM, // software trap number
  input wire logic TRAP_END, // trap service finished
  output ipt_pkg::ipt_vec_s VEC, // vector presented
  output logic VEC_VALID, // vector valid
  input wire logic VEC_ACK, // core takes vector
  output ipt_pkg::ipt_xfer_s XFER, // transfer presented
  output logic XFER_VALID, // transfer valid
  input wire logic XFER_ACK, // core did transfer
  output logic IRQ // masked trap flag interrupt
);
  import ipt_pkg::*;

  function automatic logic [8:0] vaddr(input logic [6:0] n);
    vaddr = {n, 2'b00};
  endfunction : vaddr
  localparam logic [139:0] SRC_TN = `IPT_SRC_TN;
  logic [8:0] sctl_r [0:19];
  logic [19:0] req_r, req_nxt, req_set, req_clr;
  logic [10:0] chc_r [0:7];
  logic [15:0] chs_r [0:7];
  logic [15:0] chd_r [0:7];
  logic [7:0] tfr_r, tmsk_r, tpend_r, tset, tclr_r;
  logic [15:0] sovl_r, sunl_r;
  logic [13:0] edge_r;
  logic [6:0] ext_s1_r, ext_s2_r, ext_d_r, ext_ev;
  logic rst_pend_r, swt_pend_r;
  logic [6:0] swt_num_r;
  logic [1:0] tcls_r;
  ipt_state_e state_r;
  ipt_kind_e kind_r, kind_nxt;
  logic [4:0] sel_src_r, best_i;
  logic [2:0] xch_r;
  logic [3:0] best_lvl;
  logic found;
  ipt_vec_s vec_r;
  ipt_xfer_s xfer_r;
  logic pready_r, pslverr_r, irq_r;
  logic [31:0] prdata_r;
  // apb: access phase always lasts two cycles
  wire acc1 = PSEL & PENABLE & ~pready_r;
  wire done = PSEL & PENABLE & pready_r;
  wire wr = done & PWRITE;
  wire [4:0] a_idx = PADDR[6:2];
  wire [2:0] a_ch = PADDR[6:4];
  wire [1:0] a_sub = PADDR[3:2];
  wire hit_src = PADDR[11:7] == 5'h00 && a_idx < 5'(`IPT_NSRC);
  wire hit_ch = PADDR[11:8] == `IPT_A_CHB && !PADDR[7] && a_sub != 2'h3;
  wire hit_tfr = PADDR[11:2] == 10'(`IPT_A_TFR >> 2);
  wire hit_tmsk = PADDR[11:2] == 10'(`IPT_A_TMSK >> 2);
  wire hit_sovl = PADDR[11:2] == 10'(`IPT_A_SOVL >> 2);
  wire hit_sunl = PADDR[11:2] == 10'(`IPT_A_SUNL >> 2);
  wire hit_edge = PADDR[11:2] == 10'(`IPT_A_EDGE >> 2);
  wire hit = hit_src | hit_ch | hit_tfr | hit_tmsk | hit_sovl |
    hit_sunl | hit_edge;
  wire [31:0] rd_ch = a_sub == 2'h0 ? {21'h0, chc_r[a_ch]} :
    a_sub == 2'h1 ? {16'h0, chs_r[a_ch]} : {16'h0, chd_r[a_ch]};
  wire [31:0] rdata = hit_src ? {22'h0, req_r[a_idx], sctl_r[a_idx]} :
    hit_ch ? rd_ch :
    hit_tfr ? {24'h0, tfr_r} :
    hit_tmsk ? {24'h0, tmsk_r} :
    hit_sovl ? {16'h0, sovl_r} :
    hit_sunl ? {16'h0, sunl_r} :
    hit_edge ? {18'h0, edge_r} : 32'h0;
  // only bits that were reported are cleared, so late events survive
  wire [7:0] tfr_rdclr = (done & ~PWRITE & hit_tfr) ? prdata_r[7:0] : 8'h0;
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end else begin
      pready_r <= acc1;
      pslverr_r <= acc1 & ~hit;
      if (acc1)
        prdata_r <= rdata;
    end
  end
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      tmsk_r <= 8'h00;
      sovl_r <= `IPT_RST_SOVL;
      sunl_r <= `IPT_RST_SUNL;
      edge_r <= 14'h0;
    end else if (wr) begin
      if (hit_tmsk)
        tmsk_r <= PWDATA[7:0];
      if (hit_sovl)
        sovl_r <= PWDATA[15:0];
      if (hit_sunl)
        sunl_r <= PWDATA[15:0];
      if (hit_edge)
        edge_r <= PWDATA[13:0];
    end
  end
  // external pins: two-stage synchroniser, then edge select
  wire [6:0] ext_rise = ext_s2_r & ~ext_d_r;
  wire [6:0] ext_fall = ~ext_s2_r & ext_d_r;
  always_comb begin
    for (int i = 0; i < `IPT_NEXT; i++)
      ext_ev[i] = (edge_r[2*i] & ext_rise[i]) |
        (edge_r[2*i+1] & ext_fall[i]);
  end
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      ext_s1_r <= 7'h0;
      ext_s2_r <= 7'h0;
      ext_d_r <= 7'h0;
    end else begin
      ext_s1_r <= EXT_IN;
      ext_s2_r <= ext_s1_r;
      ext_d_r <= ext_s2_r;
    end
  end
  // arbitration: strictly above core level, lower index wins a tie
  always_comb begin
    best_lvl = CPU_PRIO;
    best_i = 5'h0;
    found = 1'b0;
    for (int i = 0; i < `IPT_NSRC; i++) begin
      if (req_r[i] && sctl_r[i][`IPT_S_EN] &&
          sctl_r[i][`IPT_S_LVL] > best_lvl) begin
        best_lvl = sctl_r[i][`IPT_S_LVL];
        best_i = 5'(i);
        found = 1'b1;
      end
    end
  end

  wire [2:0] best_ch = sctl_r[best_i][`IPT_S_CH];
  wire [10:0] bcc = chc_r[best_ch];
  wire best_xfer = sctl_r[best_i][`IPT_S_ROUTE] &&
    (bcc[`IPT_C_CONT] || bcc[`IPT_C_CNT] != 8'h0);
  wire idle = state_r == ST_IDLE;
  wire take_a = |tpend_r[2:0] && tcls_r != `IPT_CLS_A;
  wire take_b = |tpend_r[7:3] && tcls_r == `IPT_CLS_NONE;
  wire go_rst = rst_pend_r;
  wire go_a = ~go_rst & take_a;
  wire go_b = ~go_rst & ~take_a & take_b;
  wire go_swt = ~go_rst & ~take_a & ~take_b & swt_pend_r;
  wire go_src = ~go_rst & ~take_a & ~take_b & ~swt_pend_r & found &
    tcls_r == `IPT_CLS_NONE;
  wire go_xfer = idle & go_src & best_xfer;
  wire go_vec = idle & (go_rst | go_a | go_b | go_swt |
    (go_src & ~best_xfer));
  wire [6:0] a_num = tpend_r[`IPT_T_NMI] ? `IPT_TN_NMI :
    tpend_r[`IPT_T_STACK_OVER_FLAG] ? `IPT_TN_STACK_OVER_FLAG : `IPT_TN_STACK_UNDER_FLAG;
  wire [7:0] a_clr = tpend_r[`IPT_T_NMI] ? 8'h01 :
    tpend_r[`IPT_T_STACK_OVER_FLAG] ? 8'h02 : 8'h04;
  wire [6:0] num_nxt = go_rst ? `IPT_TN_RST :
    go_a ? a_num :
    go_b ? `IPT_TN_B :
    go_swt ? swt_num_r : SRC_TN[7*best_i +: 7];
  wire [3:0] lvl_nxt = (go_rst | go_a | go_b) ? `IPT_LVL_TRAP :
    go_swt ? CPU_PRIO : best_lvl;
  assign kind_nxt = go_rst ? K_RST : go_a ? K_A : go_b ? K_B :
    go_swt ? K_SWT : K_INT;
  wire vack = state_r == ST_VEC && VEC_ACK;
  wire xack = state_r == ST_XFER && XFER_ACK;
  wire [10:0] xc = chc_r[xch_r];
  wire [15:0] xinc = xc[`IPT_C_WORD] ? 16'h0002 : 16'h0001;
  wire [7:0] xcnt = xc[`IPT_C_CONT] ? xc[`IPT_C_CNT] :
    xc[`IPT_C_CNT] - 8'h01;
  // flag stays set when the count runs out, so it comes back vectored
  wire xkeep = ~xc[`IPT_C_CONT] && xc[`IPT_C_CNT] == 8'h01;
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      state_r <= ST_IDLE;
      kind_r <= K_RST;
      vec_r <= '0;
      xfer_r <= '0;
      sel_src_r <= 5'h0;
      xch_r <= 3'h0;
      tclr_r <= 8'h0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          sel_src_r <= best_i;
          xch_r <= best_ch;
          if (go_xfer) begin
            state_r <= ST_XFER;
            xfer_r <= '{chs_r[best_ch], chd_r[best_ch],
              bcc[`IPT_C_WORD]};
          end else if (go_vec) begin
            state_r <= ST_VEC;
            kind_r <= kind_nxt;
            vec_r <= '{num_nxt, vaddr(num_nxt), lvl_nxt};
            tclr_r <= go_a ? a_clr : go_b ? `IPT_T_BMASK : 8'h0;
          end
        end
        ST_VEC:
          if (VEC_ACK)
            state_r <= ST_IDLE;
        ST_XFER:
          if (XFER_ACK)
            state_r <= ST_IDLE;
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // source request flags: hardware set beats any clear
  always_comb begin
    req_set = SRC_REQ | {13'h0, ext_ev};
    req_clr = 20'h0;
    if (wr && hit_src) begin
      if (PWDATA[`IPT_S_REQ])
        req_set[a_idx] = 1'b1;
      else
        req_clr[a_idx] = 1'b1;
    end
    if (vack && kind_r == K_INT)
      req_clr[sel_src_r] = 1'b1;
    if (xack && !xkeep)
      req_clr[sel_src_r] = 1'b1;
    req_nxt = req_set | (req_r & ~req_clr);
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      req_r <= 20'h0;
      for (int i = 0; i < `IPT_NSRC; i++)
        sctl_r[i] <= 9'h0;
    end else begin
      req_r <= req_nxt;
      if (wr && hit_src)
        sctl_r[a_idx] <= PWDATA[8:0];
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      for (int c = 0; c < `IPT_NCH; c++) begin
        chc_r[c] <= 11'h0;
        chs_r[c] <= 16'h0;
        chd_r[c] <= 16'h0;
      end
    end else begin
      for (int c = 0; c < `IPT_NCH; c++) begin
        if (wr && hit_ch && a_ch == 3'(c)) begin
          if (a_sub == 2'h0)
            chc_r[c] <= PWDATA[10:0];
          else if (a_sub == 2'h1)
            chs_r[c] <= PWDATA[15:0];
          else
            chd_r[c] <= PWDATA[15:0];
        end
        if (xack && xch_r == 3'(c)) begin
          chc_r[c][`IPT_C_CNT] <= xcnt;
          if (xc[`IPT_C_INCD])
            chd_r[c] <= chd_r[c] + xinc;
          else
            chs_r[c] <= chs_r[c] + xinc;
        end
      end
    end
  end

  // trap conditions
  wire stk_of = STK_ACC && STK_PTR < sovl_r;
  wire stk_uf = STK_ACC && STK_PTR > sunl_r;
  always_comb begin
    tset = 8'h0;
    tset[`IPT_T_NMI] = TRAP_IN.nmi;
    tset[`IPT_T_STACK_OVER_FLAG] = stk_of;
    tset[`IPT_T_STACK_UNDER_FLAG] = stk_uf;
    tset[`IPT_T_BOP] = TRAP_IN.bad_opcode;
    tset[`IPT_T_PRT] = TRAP_IN.prot_fault;
    tset[`IPT_T_BWO] = TRAP_IN.bad_word_op;
    tset[`IPT_T_BIA] = TRAP_IN.bad_instr;
    tset[`IPT_T_BEB] = TRAP_IN.bad_bus;
  end

  wire [7:0] tack = vack ? tclr_r : 8'h0;
  wire swt_clr = vack && kind_r == K_SWT;
  wire rst_clr = vack && kind_r == K_RST;
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      tfr_r <= 8'h0;
      tpend_r <= 8'h0;
      tcls_r <= `IPT_CLS_NONE;
      rst_pend_r <= 1'b1;
      swt_pend_r <= 1'b0;
      swt_num_r <= 7'h0;
      irq_r <= 1'b0;
    end else begin
      tfr_r <= tset | (tfr_r & ~tfr_rdclr);
      tpend_r <= tset | (tpend_r & ~tack);
      irq_r <= |(tfr_r & tmsk_r);
      rst_pend_r <= TRAP_IN.soft_rst | TRAP_IN.wdt_ovf |
        (rst_pend_r & ~rst_clr);
      swt_pend_r <= SWT_REQ | (swt_pend_r & ~swt_clr);
      if (SWT_REQ && (!swt_pend_r || swt_clr))
        swt_num_r <= SWT_NUM;
      if (vack && kind_r == K_A)
        tcls_r <= `IPT_CLS_A;
      else if (vack && kind_r == K_B)
        tcls_r <= `IPT_CLS_B;
      else if (TRAP_END || rst_clr)
        tcls_r <= `IPT_CLS_NONE;
    end
  end

  assign PRDATA = prdata_r;
  assign PREADY = pready_r;
  assign PSLVERR = pslverr_r;
  assign VEC = vec_r;
  assign VEC_VALID = state_r[1];
  assign XFER = xfer_r;
  assign XFER_VALID = state_r[2];
  assign IRQ = irq_r;
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESETN);
  sequence s_src_ready;
    idle && go_src && !best_xfer;
  endsequence
  sequence s_vec_up;
    VEC_VALID && VEC.num == SRC_TN[7*$past(best_i) +: 7];
  endsequence
  a_vec_addr: assert property (
    VEC_VALID |-> VEC.addr == {VEC.num, 2'b00})
    else $error("vector address not four times trap number");
  a_int_latency: assert property (
    s_src_ready |=> s_vec_up)
    else $error("eligible source not vectored next cycle");
  a_level_above: assert property (
    $rose(VEC_VALID) && kind_r == K_INT |-> VEC.lvl > $past(CPU_PRIO))
    else $error("interrupt taken at or below core level");
  a_flag_clear: assert property (
    vack && kind_r == K_INT |=>
      !req_r[sel_src_r] || $past(req_set[sel_src_r]))
    else $error("request flag not cleared on vector");
  a_stack_over: assert property (
    STK_ACC && STK_PTR < sovl_r |=> tfr_r[`IPT_T_STACK_OVER_FLAG] && tpend_r[1])
    else $error("stack overflow not flagged");
  a_nmi_vector: assert property (
    idle && tpend_r[0] && !rst_pend_r && tcls_r != `IPT_CLS_A |=>
      VEC_VALID && VEC.num == `IPT_TN_NMI)
    else $error("nmi not vectored at once");
  a_classb_num: assert property (
    $rose(VEC_VALID) && kind_r == K_B |-> VEC.num == `IPT_TN_B &&
      VEC.addr == 9'h028)
    else $error("class b vector wrong");
  a_reset_vec: assert property (
    $rose(VEC_VALID) && kind_r == K_RST |-> VEC.num == 7'h00 &&
      VEC.addr == 9'h000)
    else $error("reset vector wrong");
  a_trap_blocks: assert property (
    tcls_r != `IPT_CLS_NONE && idle |=> !XFER_VALID)
    else $error("transfer started during trap service");
  a_xfer_count: assert property (
    xack && !xc[`IPT_C_CONT] && xc[`IPT_C_CNT] != 8'h0 |=>
      chc_r[$past(xch_r)][`IPT_C_CNT] == $past(xc[`IPT_C_CNT]) - 8'h01)
    else $error("transfer counter not decremented");
endmodule : ipt_top

// ---- sim/ipt_core_model.sv ----
/*
  Core side model: takes offered vectors and event transfers.
  Assumes the unit holds each offer until it sees the acknowledge.
*/
`timescale 1ns/1ps
module ipt_core_model (
  input wire logic clk, // unit clock
  input wire logic rst_n, // async reset, active low
  input wire logic [3:0] delay, // wait cycles before each acknowledge
  input wire logic vec_valid, // vector offered
  input wire logic xfer_valid, // transfer offered
  output logic vec_ack, // vector taken, one cycle
  output logic xfer_ack // stolen transfer cycle, one cycle
);
  logic [3:0] wait_r;
  logic offered;
  logic go;
  assign offered = (vec_valid & ~vec_ack) | (xfer_valid & ~xfer_ack);
  assign go = offered && (wait_r >= delay);
  // a slow core lets offers stand, so the unit must hold them unchanged
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_r <= 4'h0;
      vec_ack <= 1'b0;
      xfer_ack <= 1'b0;
    end else begin
      wait_r <= (offered && !go) ? wait_r + 4'h1 : 4'h0;
      vec_ack <= go && vec_valid && !vec_ack;
      xfer_ack <= go && xfer_valid && !vec_valid && !xfer_ack;
    end
  end
endmodule : ipt_core_model

// ---- sim/ipt_top_tb_top.sv ----
/*
  Self-checking bench of the interrupt, event transfer and trap unit.
  Assumes the core model acknowledges every vector and transfer.
*/
`timescale 1ns/1ps
`include "ipt_defines.svh"
module ipt_top_tb_top;
  import ipt_pkg::*;
  logic CLOCK = 1'b0;
  logic RESETN = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, VEC_VALID, VEC_ACK, XFER_VALID, XFER_ACK, IRQ;
  logic [19:0] SRC_REQ = 20'h0;
  logic [6:0] EXT_IN = 7'h00;
  ipt_trap_s TRAP_IN = '0;
  logic STK_ACC = 1'b0;
  logic [15:0] STK_PTR = 16'h0400;
  logic [3:0] CPU_PRIO = 4'h0;
  logic SWT_REQ = 1'b0;
  logic [6:0] SWT_NUM = 7'h00;
  logic TRAP_END = 1'b0;
  ipt_vec_s VEC;
  ipt_xfer_s XFER;
  logic [3:0] dly = 4'h0;
  int n_mismatch = 0;
  int n_checks = 0;
  ipt_vec_s vq[$];
  ipt_xfer_s xq[$];
  logic [31:0] rdv;
  logic err;
  logic [6:0] swn[3] = '{7'h00, 7'h7f, 7'h41};

  always #2.5 CLOCK = ~CLOCK;

  ipt_top DUT (.CLOCK(CLOCK), .RESETN(RESETN), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .SRC_REQ(SRC_REQ), .EXT_IN(EXT_IN), .TRAP_IN(TRAP_IN),
    .STK_ACC(STK_ACC), .STK_PTR(STK_PTR), .CPU_PRIO(CPU_PRIO),
    .SWT_REQ(SWT_REQ), .SWT_NUM(SWT_NUM), .TRAP_END(TRAP_END), .VEC(VEC),
    .VEC_VALID(VEC_VALID), .VEC_ACK(VEC_ACK), .XFER(XFER),
    .XFER_VALID(XFER_VALID), .XFER_ACK(XFER_ACK), .IRQ(IRQ));

  ipt_core_model core (.clk(CLOCK), .rst_n(RESETN), .delay(dly),
    .vec_valid(VEC_VALID), .xfer_valid(XFER_VALID), .vec_ack(VEC_ACK),
    .xfer_ack(XFER_ACK));

  // log taken units mid-cycle, clear of the edge that commits them
  always @(negedge CLOCK) begin
    if (VEC_VALID === 1'b1 && VEC_ACK === 1'b1)
      vq.push_back(VEC);
    if (XFER_VALID === 1'b1 && XFER_ACK === 1'b1)
      xq.push_back(XFER);
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_up();
    n_mismatch++;
    $display("BAD at %0t: wait ran out", $time);
    give_verdict();
  endtask : give_up

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int t = 0;
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLOCK);
      t++;
    end while (PREADY !== 1'b1 && t < 20);
    if (t >= 20)
      give_up();
    rdv = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rdv, e);
  endtask : rd

  // one-cycle pulses on the request side of the unit
  task automatic fire(input logic [19:0] s, input logic [7:0] tr,
                      input logic sw, input logic stk);
    @(posedge CLOCK);
    SRC_REQ <= s;
    TRAP_IN <= ipt_trap_s'(tr);
    SWT_REQ <= sw;
    STK_ACC <= stk;
    @(posedge CLOCK);
    SRC_REQ <= 20'h0;
    TRAP_IN <= '0;
    SWT_REQ <= 1'b0;
    STK_ACC <= 1'b0;
  endtask : fire

  task automatic end_trap();
    @(posedge CLOCK);
    TRAP_END <= 1'b1;
    @(posedge CLOCK);
    TRAP_END <= 1'b0;
  endtask : end_trap

  task automatic exp_vec(input logic [6:0] n, input logic [3:0] l,
                         input int lim);
    int t = 0;
    ipt_vec_s v;
    while (vq.size() == 0 && t < lim) begin
      @(posedge CLOCK);
      t++;
    end
    if (vq.size() == 0)
      give_up();
    v = vq.pop_front();
    check({12'h0, v}, {12'h0, n, n, 2'b00, l});
  endtask : exp_vec

  task automatic exp_xfer(input logic [15:0] s, input logic [15:0] d,
                          input logic w);
    int t = 0;
    ipt_xfer_s x;
    while (xq.size() == 0 && t < 30) begin
      @(posedge CLOCK);
      t++;
    end
    if (xq.size() == 0)
      give_up();
    x = xq.pop_front();
    check({16'h0, x.src}, {16'h0, s});
    check({15'h0, x.dst, x.word}, {15'h0, d, w});
  endtask : exp_xfer

  task automatic exp_none(input int n);
    repeat (n) @(posedge CLOCK);
    check(32'(vq.size() + xq.size()), 32'h0);
  endtask : exp_none

  initial begin
    repeat (20000) @(posedge CLOCK);
    give_up();
  end

  initial begin
    repeat (4) @(posedge CLOCK);
    RESETN <= 1'b1;
    exp_vec(`IPT_TN_RST, `IPT_LVL_TRAP, 6);
    rd(`IPT_A_SOVL, 32'h0000_0000);
    rd(`IPT_A_SUNL, 32'h0000_ffff);
    apb(1'b0, 12'h050, 32'h0);
    check({31'h0, err}, 32'h1);
    CPU_PRIO <= 4'h2;
    wr(12'h00c, 32'h105);
    fire(20'h8, 8'h00, 1'b0, 1'b0);
    exp_vec(7'h1c, 4'h5, 12);
    rd(12'h00c, 32'h105);
    CPU_PRIO <= 4'h5;
    wr(12'h00c, 32'h305);
    exp_none(20);
    CPU_PRIO <= 4'h4;
    exp_vec(7'h1c, 4'h5, 12);
    CPU_PRIO <= 4'hf;
    wr(12'h000, 32'h303);
    wr(12'h04c, 32'h309);
    exp_none(4);
    CPU_PRIO <= 4'h0;
    exp_vec(7'h2f, 4'h9, 12);
    exp_vec(7'h19, 4'h3, 12);
    CPU_PRIO <= 4'h3;
    foreach (swn[i]) begin
      SWT_NUM <= swn[i];
      fire(20'h0, 8'h00, 1'b1, 1'b0);
      exp_vec(swn[i], 4'h3, 12);
    end
    // limits are strict: a pointer equal to a limit is legal
    wr(`IPT_A_SOVL, 32'h100);
    wr(`IPT_A_SUNL, 32'h200);
    wr(`IPT_A_TMSK, 32'h1);
    STK_PTR <= 16'h0100;
    fire(20'h0, 8'h00, 1'b0, 1'b1);
    STK_PTR <= 16'h0200;
    fire(20'h0, 8'h00, 1'b0, 1'b1);
    exp_none(8);
    STK_PTR <= 16'h00ff;
    fire(20'h0, 8'h00, 1'b0, 1'b1);
    exp_vec(`IPT_TN_STACK_OVER_FLAG, `IPT_LVL_TRAP, 12);
    end_trap();
    STK_PTR <= 16'h0201;
    fire(20'h0, 8'h00, 1'b0, 1'b1);
    exp_vec(`IPT_TN_STACK_UNDER_FLAG, `IPT_LVL_TRAP, 12);
    end_trap();
    check({31'h0, IRQ}, 32'h0);
    fire(20'h0, 8'h80, 1'b0, 1'b0);
    exp_vec(`IPT_TN_NMI, `IPT_LVL_TRAP, 12);
    STK_PTR <= 16'h00ff;
    fire(20'h0, 8'h00, 1'b0, 1'b1);
    exp_none(8);
    end_trap();
    exp_vec(`IPT_TN_STACK_OVER_FLAG, `IPT_LVL_TRAP, 12);
    end_trap();
    check({31'h0, IRQ}, 32'h1);
    rd(`IPT_A_TFR, 32'h07);
    exp_none(3);
    check({31'h0, IRQ}, 32'h0);
    for (int k = 1; k < 6; k++) begin
      fire(20'h0, 8'h80 >> k, 1'b0, 1'b0);
      exp_vec(`IPT_TN_B, `IPT_LVL_TRAP, 12);
      end_trap();
    end
    rd(`IPT_A_TFR, 32'hf8);
    for (int k = 6; k < 8; k++) begin
      fire(20'h0, 8'h80 >> k, 1'b0, 1'b0);
      exp_vec(`IPT_TN_RST, `IPT_LVL_TRAP, 12);
    end
    fire(20'h0, 8'h40, 1'b0, 1'b0);
    exp_vec(`IPT_TN_B, `IPT_LVL_TRAP, 12);
    wr(12'h00c, 32'h305);
    exp_none(10);
    fire(20'h0, 8'h80, 1'b0, 1'b0);
    exp_vec(`IPT_TN_NMI, `IPT_LVL_TRAP, 12);
    end_trap();
    end_trap();
    exp_vec(7'h1c, 4'h5, 12);
    // slow core: transfers and vectors must stand until taken
    dly <= 4'h3;
    wr(12'h120, 32'h302);
    wr(12'h124, 32'h1000);
    wr(12'h128, 32'h2000);
    wr(12'h014, 32'h156);
    fire(20'h20, 8'h00, 1'b0, 1'b0);
    exp_xfer(16'h1000, 16'h2000, 1'b1);
    fire(20'h20, 8'h00, 1'b0, 1'b0);
    exp_xfer(16'h1000, 16'h2002, 1'b1);
    exp_vec(7'h1e, 4'h6, 20);
    rd(12'h120, 32'h300);
    wr(12'h170, 32'h400);
    wr(12'h174, 32'h0010);
    wr(12'h178, 32'h3000);
    wr(12'h018, 32'h1f4);
    for (int k = 0; k < 3; k++) begin
      fire(20'h40, 8'h00, 1'b0, 1'b0);
      exp_xfer(16'h0010 + 16'(k), 16'h3000, 1'b0);
    end
    exp_none(10);
    rd(12'h170, 32'h400);
    rd(12'h128, 32'h2004);
    dly <= 4'h0;
    CPU_PRIO <= 4'h0;
    wr(`IPT_A_EDGE, 32'h39);
    for (int k = 0; k < 3; k++)
      wr(12'(4 * k), 32'h101);
    EXT_IN <= 7'h07;
    exp_vec(7'h19, 4'h1, 20);
    exp_vec(7'h1b, 4'h1, 20);
    exp_none(10);
    EXT_IN <= 7'h00;
    exp_vec(7'h1a, 4'h1, 20);
    exp_vec(7'h1b, 4'h1, 20);
    exp_none(10);
    give_verdict();
  end
endmodule : ipt_top_tb_top
